// ### hdl/irq_core_config.sv
// Behaviour
// - three sources: external pin edge, timer overflow, upper port-B change
// - control register holds a flag and an enable per source, plus global enable
// - global enable bit 7 set lets unmasked sources interrupt; clear blocks all
// - reset clears the global enable
// - return from interrupt leaves the routine and sets global enable together
// - acceptance clears global enable, pushes return address, loads vector 0004h
// - flags set on their events regardless of any enable
// - external events reach the vector three or four cycles later
// - clearing global enable ignores next-cycle interrupts and inserts a no-op
// - ignored requests stay pending until global enable returns
// - config bit 6 picks external pin edge: one rising, zero falling
// - config register is read/write and resets to all ones
// - config bit 7 one disables port-B pull-ups, zero enables per latch
// - timer clock source zero is instruction clock, one external pin transitions
// - config bit 4 one counts falling external edges, zero rising
// - config bit 3 gives prescaler to watchdog when set, timer when clear
// - rate code n divides timer by 2^(n+1), watchdog by 2^n
// - timer overflow flag sets on rollover from ffh to 00h
// - timer enable at bit 5, flag at bit 2; clearing enable masks it
// - return pops stack into program counter and takes two cycles
`timescale 1ns/1ns
`default_nettype none
`include "irq_core_defines.svh"

module irq_core_config
    import irq_core_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       reset_n_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       reg_wr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_rd_in,
    output var  logic [7:0] reg_rdata_out,
    input  wire logic       ext_irq_pin_in,
    input  wire logic       timer_ext_clock_pin_in,
    input  wire logic [3:0] portb_upper_pins_in,
    input  wire logic       portb_read_in,
    input  wire logic       watchdog_tick_in,
    input  wire logic       return_from_irq_in,
    output var  logic       irq_request_out,
    output var  logic       vector_load_out,
    output var  logic [12:0] vector_addr_out,
    output var  logic       stack_push_out,
    output var  logic       stack_pop_out,
    output var  logic       nop_insert_out,
    output var  logic       watchdog_tick_out,
    output var  core_config_t core_config_out,
    output var  irq_control_t irq_control_out
);

    irq_control_t irq_ctl;
    core_config_t cfg;
    irq_state_t   state;
    logic [7:0]   timer_zero_count;
    logic [7:0]   prescaler;
    logic [1:0]   timer_inhibit;
    logic [1:0]   return_count;
    logic         ext_pin_prev;
    logic         tclk_pin_prev;
    logic [3:0]   portb_latch;

    logic         ext_event;
    logic         tclk_edge;
    logic         src_tick;
    logic         psc_in_tick;
    logic         psc_out_tick;
    logic         timer_tick;
    logic         timer_rollover;
    logic         pbc_event;
    logic         ctl_write;
    logic         cfg_write;
    logic         tmr_write;
    logic         accept;
    logic         next_request;

    // prescaler terminal mask: timer ratio 2^(n+1), watchdog 2^n
    function automatic logic [7:0] rate_mask(input logic [2:0] rate, input logic to_watchdog);
        logic [8:0] full;
        full = 9'h000;
        full = (9'h001 << (to_watchdog ? {1'b0, rate} : ({1'b0, rate} + 4'h1))) - 9'h001;
        return full[7:0];
    endfunction

    function automatic logic is_ctl_addr(input logic [7:0] addr);
        return (addr == `IRQ_CONTROL_ADDR_B0) || (addr == `IRQ_CONTROL_ADDR_B1);
    endfunction

    assign ctl_write = reg_wr_in && is_ctl_addr(reg_addr_in);
    assign cfg_write = reg_wr_in && (reg_addr_in == `CORE_CONFIG_ADDR);
    assign tmr_write = reg_wr_in && (reg_addr_in == `TIMER_COUNT_ADDR);

    // edge detection on synchronous inputs
    assign ext_event = cfg.ext_irq_edge_select ? (ext_irq_pin_in && !ext_pin_prev)
                                               : (!ext_irq_pin_in && ext_pin_prev);
    assign tclk_edge = cfg.timer_source_edge ? (!timer_ext_clock_pin_in && tclk_pin_prev)
        : (timer_ext_clock_pin_in && !tclk_pin_prev);
    assign src_tick  = cfg.timer_clock_source ? tclk_edge : 1'b1;

    // shared prescaler feeds either the timer or the watchdog
    assign psc_in_tick  = cfg.prescaler_assign ? watchdog_tick_in : src_tick;
    assign psc_out_tick = psc_in_tick &&
        ((prescaler & rate_mask(cfg.prescaler_rate, cfg.prescaler_assign))
         == rate_mask(cfg.prescaler_rate, cfg.prescaler_assign));
    assign timer_tick   = (cfg.prescaler_assign ? src_tick : psc_out_tick)
                          && (timer_inhibit == 2'h0) && !tmr_write;
    assign timer_rollover = timer_tick && (timer_zero_count == 8'hff);

    assign pbc_event = (portb_upper_pins_in != portb_latch);

    assign next_request = irq_ctl.global_irq_enable &&
        |({irq_ctl.timer_overflow_enable, irq_ctl.ext_irq_enable, irq_ctl.portb_change_enable}
          & {irq_ctl.timer_overflow_flag, irq_ctl.ext_irq_flag, irq_ctl.portb_change_flag});

    // the cycle after a global-enable clear is a no-op, so nothing is taken then
    assign accept = (state == ST_IDLE) && irq_request_out && irq_ctl.global_irq_enable
                    && !nop_insert_out;

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            ext_pin_prev  <= 1'b0;
            tclk_pin_prev <= 1'b0;
        end else begin
            ext_pin_prev  <= ext_irq_pin_in;
            tclk_pin_prev <= timer_ext_clock_pin_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            portb_latch <= 4'h0;
        end else if (portb_read_in) begin
            portb_latch <= portb_upper_pins_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            cfg <= `CORE_CONFIG_RESET;
        end else if (cfg_write) begin
            cfg <= reg_wdata_in;
        end
    end

    // a config write restarts the prescaler so a new ratio starts clean
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in || cfg_write) begin
            prescaler <= 8'h00;
        end else if (tmr_write && !cfg.prescaler_assign) begin
            prescaler <= 8'h00;
        end else if (psc_in_tick) begin
            prescaler <= prescaler + 8'h01;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            watchdog_tick_out <= 1'b0;
        end else begin
            watchdog_tick_out <= cfg.prescaler_assign ? psc_out_tick : watchdog_tick_in;
        end
    end

    // a timer write holds off counting for two cycles
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            timer_zero_count <= `TIMER_COUNT_RESET;
            timer_inhibit    <= 2'h0;
        end else if (tmr_write) begin
            timer_zero_count <= reg_wdata_in;
            timer_inhibit    <= `TIMER_WRITE_INHIBIT;
        end else begin
            if (timer_inhibit != 2'h0) begin
                timer_inhibit <= timer_inhibit - 2'h1;
            end
            if (timer_tick) begin
                timer_zero_count <= timer_zero_count + 8'h01;
            end
        end
    end

    // flags: hardware set wins over a software write in the same cycle
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            irq_ctl <= `IRQ_CONTROL_RESET;
        end else begin
            if (ctl_write) begin
                irq_ctl.global_irq_enable     <= reg_wdata_in[`GLOBAL_EN_BIT];
                irq_ctl.timer_overflow_enable <= reg_wdata_in[`TOV_EN_BIT];
                irq_ctl.ext_irq_enable        <= reg_wdata_in[`EXT_EN_BIT];
                irq_ctl.portb_change_enable   <= reg_wdata_in[`PBC_EN_BIT];
            end
            if (accept) begin
                irq_ctl.global_irq_enable <= 1'b0;
            end else if (return_from_irq_in && state == ST_IDLE) begin
                irq_ctl.global_irq_enable <= 1'b1;
            end
            irq_ctl.reserved <= 1'b0;
            irq_ctl.timer_overflow_flag <= timer_rollover ||
                (ctl_write ? reg_wdata_in[`TOV_FLAG_BIT] : irq_ctl.timer_overflow_flag);
            irq_ctl.ext_irq_flag <= ext_event ||
                (ctl_write ? reg_wdata_in[`EXT_FLAG_BIT] : irq_ctl.ext_irq_flag);
            irq_ctl.portb_change_flag <= pbc_event ||
                (ctl_write ? reg_wdata_in[`PBC_FLAG_BIT] : irq_ctl.portb_change_flag);
        end
    end

    // pending flags are never touched by gating, so ignored requests return later
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            irq_request_out <= 1'b0;
        end else begin
            irq_request_out <= next_request && !accept;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            nop_insert_out <= 1'b0;
        end else begin
            nop_insert_out <= ctl_write && irq_ctl.global_irq_enable
                              && !reg_wdata_in[`GLOBAL_EN_BIT] && !accept;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            state           <= ST_IDLE;
            return_count    <= 2'h0;
            vector_load_out <= 1'b0;
            stack_push_out  <= 1'b0;
            stack_pop_out   <= 1'b0;
            vector_addr_out <= 13'h0000;
        end else begin
            vector_load_out <= 1'b0;
            stack_push_out  <= 1'b0;
            stack_pop_out   <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (accept) begin
                        state           <= ST_ENTRY;
                        vector_load_out <= 1'b1;
                        stack_push_out  <= 1'b1;
                        vector_addr_out <= `IRQ_VECTOR;
                    end else if (return_from_irq_in) begin
                        state         <= ST_RETURN;
                        stack_pop_out <= 1'b1;
                        return_count  <= `RETURN_CYCLES - 2'h1;
                    end
                end
                ST_ENTRY: begin
                    state <= ST_IDLE;
                end
                ST_RETURN: begin
                    if (return_count <= 2'h1) begin
                        state <= ST_IDLE;
                    end
                    return_count <= return_count - 2'h1;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= `READ_UNMAPPED;
        end else if (reg_rd_in) begin
            if (is_ctl_addr(reg_addr_in)) begin
                reg_rdata_out <= irq_ctl;
            end else if (reg_addr_in == `CORE_CONFIG_ADDR) begin
                reg_rdata_out <= cfg;
            end else if (reg_addr_in == `TIMER_COUNT_ADDR) begin
                reg_rdata_out <= timer_zero_count;
            end else begin
                reg_rdata_out <= `READ_UNMAPPED;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            core_config_out <= `CORE_CONFIG_RESET;
            irq_control_out <= `IRQ_CONTROL_RESET;
        end else begin
            core_config_out <= cfg;
            irq_control_out <= irq_ctl;
        end
    end

    sequence s_entry;
        vector_load_out && stack_push_out;
    endsequence

    property p_reset_state;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        !$past(reset_n_in) |-> !irq_ctl.global_irq_enable && cfg == 8'hff;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset values wrong");

    property p_accept_entry;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        accept |=> s_entry ##0 !irq_ctl.global_irq_enable ##0 vector_addr_out == 13'h0004;
    endproperty
    a_accept_entry: assert property (p_accept_entry) else $error("entry missing");

    property p_request_needs_enable;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        irq_request_out |-> $past(irq_ctl.global_irq_enable);
    endproperty
    a_request_needs_enable: assert property (p_request_needs_enable)
        else $error("request without global enable");

    property p_ext_latency;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        ext_event && irq_ctl.ext_irq_enable && irq_ctl.global_irq_enable && state == ST_IDLE
        && !ctl_write && !return_from_irq_in && !irq_request_out && !nop_insert_out
        |-> ##[2:3] vector_load_out;
    endproperty
    a_ext_latency: assert property (p_ext_latency) else $error("external latency");

    property p_flag_sets;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        timer_rollover |=> irq_ctl.timer_overflow_flag && timer_zero_count == 8'h00;
    endproperty
    a_flag_sets: assert property (p_flag_sets) else $error("overflow flag lost");

    property p_nop_blocks;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        nop_insert_out |-> !accept ##1 !vector_load_out;
    endproperty
    a_nop_blocks: assert property (p_nop_blocks) else $error("taken during no-op");

    property p_return;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        return_from_irq_in && state == ST_IDLE && !accept
        |=> stack_pop_out && irq_ctl.global_irq_enable && state == ST_RETURN
            ##1 state == ST_IDLE;
    endproperty
    a_return: assert property (p_return) else $error("return sequence");

    property p_ext_edge_flag;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        ext_event |=> irq_ctl.ext_irq_flag;
    endproperty
    a_ext_edge_flag: assert property (p_ext_edge_flag) else $error("pin flag lost");

    property p_pbc_flag;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        portb_upper_pins_in != portb_latch |=> irq_ctl.portb_change_flag;
    endproperty
    a_pbc_flag: assert property (p_pbc_flag) else $error("change flag lost");

endmodule
`default_nettype wire

// ### hdl/irq_core_defines.svh
`ifndef IRQ_CORE_DEFINES_SVH
`define IRQ_CORE_DEFINES_SVH

// register addresses, both banks decoded in full
`define TIMER_COUNT_ADDR     8'h01
`define IRQ_CONTROL_ADDR_B0  8'h0b
`define IRQ_CONTROL_ADDR_B1  8'h8b
`define CORE_CONFIG_ADDR     8'h81

// irq_control field positions
`define GLOBAL_EN_BIT        7
`define TOV_EN_BIT           5
`define EXT_EN_BIT           4
`define PBC_EN_BIT           3
`define TOV_FLAG_BIT         2
`define EXT_FLAG_BIT         1
`define PBC_FLAG_BIT         0

// reset values
`define IRQ_CONTROL_RESET    8'h00
`define CORE_CONFIG_RESET    8'hff
`define TIMER_COUNT_RESET    8'h00
`define READ_UNMAPPED        8'h00

// interrupt vector and timing counts
`define IRQ_VECTOR           13'h0004
`define TIMER_WRITE_INHIBIT  2'h2
`define RETURN_CYCLES        2'h2

`endif

// ### hdl/irq_core_pkg.sv
package irq_core_pkg;

    typedef struct packed {
        logic global_irq_enable;
        logic reserved;
        logic timer_overflow_enable;
        logic ext_irq_enable;
        logic portb_change_enable;
        logic timer_overflow_flag;
        logic ext_irq_flag;
        logic portb_change_flag;
    } irq_control_t;

    typedef struct packed {
        logic       portb_pullup_disable;
        logic       ext_irq_edge_select;
        logic       timer_clock_source;
        logic       timer_source_edge;
        logic       prescaler_assign;
        logic [2:0] prescaler_rate;
    } core_config_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_ENTRY  = 3'b010,
        ST_RETURN = 3'b100
    } irq_state_t;

endpackage

// ### verification/core_model.sv
`timescale 1ns/1ns
`default_nettype none
// stands in for the core sequencer: follows vector loads and the return stack
module core_model (
    input  wire logic        clk_sys_in,
    input  wire logic        vector_load_in,
    input  wire logic [12:0] vector_addr_in,
    input  wire logic        stack_push_in,
    input  wire logic        stack_pop_in,
    output var  logic        return_from_irq_out,
    output var  logic [12:0] pc_out,
    output var  logic [2:0]  depth_out
);
    initial begin
        return_from_irq_out = 1'b0;
        pc_out = 13'h0000;
        depth_out = 3'h0;
    end

    always @(posedge clk_sys_in) begin
        if (vector_load_in === 1'b1) begin
            pc_out <= vector_addr_in;
        end
        // an unbalanced pop is left to wrap so the bench sees the damage
        if (stack_push_in === 1'b1) begin
            depth_out <= depth_out + 3'h1;
        end else if (stack_pop_in === 1'b1) begin
            depth_out <= depth_out - 3'h1;
        end
    end

    // a slow service routine is modelled by a longer delay before the return
    task automatic do_return(input int delay);
        repeat (delay) @(negedge clk_sys_in);
        return_from_irq_out = 1'b1;
        @(negedge clk_sys_in);
        return_from_irq_out = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import irq_core_pkg::*;
    logic         clk_sys_in = 1'b0;
    logic         reset_n_in = 1'b0;
    logic [7:0]   reg_addr_in = 8'h00;
    logic         reg_wr_in = 1'b0;
    logic [7:0]   reg_wdata_in = 8'h00;
    logic         reg_rd_in = 1'b0;
    logic [7:0]   reg_rdata_out;
    logic         ext_irq_pin_in = 1'b0;
    logic         timer_ext_clock_pin_in = 1'b0;
    logic [3:0]   portb_upper_pins_in = 4'h0;
    logic         portb_read_in = 1'b0;
    logic         watchdog_tick_in = 1'b0;
    logic         return_from_irq_in;
    logic         irq_request_out;
    logic         vector_load_out;
    logic [12:0]  vector_addr_out;
    logic         stack_push_out;
    logic         stack_pop_out;
    logic         nop_insert_out;
    logic         watchdog_tick_out;
    core_config_t core_config_out;
    irq_control_t irq_control_out;
    logic [12:0]  pc;
    logic [2:0]   depth;
    logic [7:0]   rnd = 8'h07;
    logic [7:0]   expq[$];
    logic         rd_d = 1'b0;
    int           failures = 0;
    int           checks = 0;
    int           cycles = 0;
    int           wd = 0;
    int           n;

    irq_core_config irq_core_config_inst (.clk_sys_in, .reset_n_in, .reg_addr_in, .reg_wr_in,
        .reg_wdata_in, .reg_rd_in, .reg_rdata_out, .ext_irq_pin_in, .timer_ext_clock_pin_in,
        .portb_upper_pins_in, .portb_read_in, .watchdog_tick_in, .return_from_irq_in,
        .irq_request_out, .vector_load_out, .vector_addr_out, .stack_push_out, .stack_pop_out,
        .nop_insert_out, .watchdog_tick_out, .core_config_out, .irq_control_out);

    core_model core_model_inst (.clk_sys_in, .vector_load_in(vector_load_out),
        .vector_addr_in(vector_addr_out), .stack_push_in(stack_push_out),
        .stack_pop_in(stack_pop_out), .return_from_irq_out(return_from_irq_in),
        .pc_out(pc), .depth_out(depth));

    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge clk_sys_in);
        reg_wr_in = 1'b0;
    endtask

    // the expected byte is queued here and compared by the read monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys_in);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        expq.push_back(e);
        @(negedge clk_sys_in);
        reg_rd_in = 1'b0;
    endtask

    task automatic pulse(ref logic s);
        @(negedge clk_sys_in);
        s = 1'b1;
        @(negedge clk_sys_in);
        s = 1'b0;
    endtask

    // counts edges until entry, bounded so a missing entry cannot hang the run
    task automatic wait_vec(output int cnt);
        cnt = 0;
        while (vector_load_out !== 1'b1 && cnt < 12) begin
            @(posedge clk_sys_in);
            #1;
            cnt++;
        end
    endtask

    always @(posedge clk_sys_in) begin
        rd_d <= reg_rd_in;
        cycles++;
        if (watchdog_tick_out === 1'b1) begin
            wd++;
        end
        if (cycles == 4000) begin
            failures++;
            stop_test();
        end
    end

    always @(negedge clk_sys_in) begin
        if (rd_d === 1'b1) begin
            if (expq.size() == 0) begin
                check(16'hdead, 16'h0000);
            end else begin
                check(reg_rdata_out, expq.pop_front());
            end
        end
    end

    initial begin
        repeat (5) @(negedge clk_sys_in);
        reset_n_in = 1'b1;
        rd(8'h81, 8'hff);
        rd(8'h0b, 8'h00);
        rd(8'h20, 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            wr(8'h81, rnd);
            @(negedge clk_sys_in);
            check(core_config_out, rnd);
            rd(8'h81, rnd);
        end
        $display("test config access done");
        wr(8'h81, 8'h68);
        wr(8'h0b, 8'h90);
        @(negedge clk_sys_in);
        ext_irq_pin_in = 1'b1;
        wait_vec(n);
        check(n == 3 || n == 4, 1'b1);
        check(vector_addr_out, 13'h0004);
        check(stack_push_out, 1'b1);
        rd(8'h8b, 8'h12);
        check(irq_control_out, 8'h12);
        check(pc, 13'h0004);
        wr(8'h0b, 8'h10);
        core_model_inst.do_return(2);
        check(stack_pop_out, 1'b1);
        rd(8'h0b, 8'h90);
        check(depth, 3'h0);
        wr(8'h0b, 8'h10);
        check(nop_insert_out, 1'b1);
        $display("test external entry and return done");
        wr(8'h81, 8'h48);
        wr(8'h0b, 8'h20);
        wr(8'h01, 8'hff);
        repeat (6) @(negedge clk_sys_in);
        rd(8'h0b, 8'h24);
        check(irq_request_out, 1'b0);
        wr(8'h81, 8'h68);
        wr(8'h0b, 8'ha4);
        wait_vec(n);
        check(vector_load_out, 1'b1);
        wr(8'h0b, 8'h20);
        core_model_inst.do_return(5);
        repeat (2) @(negedge clk_sys_in);
        rd(8'h0b, 8'ha0);
        check(irq_request_out, 1'b0);
        $display("test timer overflow done");
        pulse(portb_read_in);
        @(negedge clk_sys_in);
        portb_upper_pins_in = rnd[3:0] | 4'h1;
        repeat (2) @(negedge clk_sys_in);
        rd(8'h0b, 8'ha1);
        pulse(portb_read_in);
        wr(8'h0b, 8'h00);
        rd(8'h0b, 8'h00);
        $display("test port change done");
        for (int r = 0; r < 3; r++) begin
            wr(8'h81, 8'h68 | 8'(r));
            wd = 0;
            repeat (8) pulse(watchdog_tick_in);
            repeat (2) @(negedge clk_sys_in);
            check(16'(wd), 16'(8 >> r));
        end
        $display("test watchdog prescaler done");
        repeat (3) @(negedge clk_sys_in);
        stop_test();
    end
endmodule
`default_nettype wire
